// ---- rtl/shp_cfg.svh ----
// constants of the sensor serial host port
`ifndef SHP_CFG_SVH
`define SHP_CFG_SVH
// upper six bits of the two-wire slave address; the strap pin gives bit 0
`define SHP_I2C_ADDR_HI 6'h3B
// position of the read/write flag in the SPI control byte
`define SHP_RW_BIT 7
`define SHP_CNT_LAST 3'h7
`define SHP_CLK_PERIOD_NS 25
// least pause with SCK held high after each byte of an SPI read
`define SHP_RD_GAP_NS 250
`define SHP_RD_GAP_CYC ((`SHP_RD_GAP_NS + `SHP_CLK_PERIOD_NS - 1) / `SHP_CLK_PERIOD_NS)
`define SHP_STRAP_TAKE 2'h2
`define SHP_STRAP_DONE 2'h3
`endif

// ---- rtl/shp_pkg.sv ----
// types of the sensor serial host port
package shp_pkg;
  typedef enum logic [2:0] {I_IDLE, I_RX, I_ACK, I_ACKH, I_TX, I_MACK} shp_i2c_st_t;
  typedef enum logic [1:0] {K_ADDR, K_PTR, K_DATA} shp_kind_t;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } shp_req_t;
  typedef struct packed {
    logic [1:0] csb_s;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [1:0] sdo_s;
    logic [2:0] wt_s;
    logic [2:0] rt_s;
    logic spi_sel;
    logic [1:0] strap;
    logic addr_lsb;
    logic m3;
    logic irq;
    logic int_en;
    shp_i2c_st_t st;
    shp_kind_t kind;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic [6:0] ptr;
    logic sda_oe;
    logic fetch;
    logic [7:0] rd_byte;
    shp_req_t req;
  } shp_core_t;
  typedef struct packed {
    logic [2:0] cnt;
    logic [6:0] sh;
    logic ctrl_done;
    logic rw;
  } shp_bit_t;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic wt;
    logic rt;
  } shp_xfer_t;
endpackage : shp_pkg

// ---- rtl/shp_serial_port.sv ----
// serial host port: two-wire slave and mode-3 SPI slave in front of a register port
`timescale 1ns/100ps
`include "shp_cfg.svh"
module shp_serial_port (
  // system clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // chip select and serial clock pins
  input wire logic cs_n,
  input wire logic sck,
  // bidirectional data pin
  input wire logic sdi_sense,
  output logic sdi_drive,
  output logic sdi_oe,
  // serial-out / address strap pin
  input wire logic serial_out_addr_pin_sense,
  output logic serial_out_addr_pin_drive,
  output logic serial_out_addr_pin_oe,
  // core side: mode, interrupt, register access
  input wire logic spi_3wire,
  input wire logic int_en,
  input wire logic irq,
  input wire logic [7:0] reg_rdata,
  output shp_pkg::shp_req_t reg_req,
  output logic spi_sel
);
  // ==========================================================
  // link domain (SPI serial clock)
  shp_pkg::shp_bit_t bit_ff, nxt_bit;
  shp_pkg::shp_xfer_t xfer_ff, nxt_xfer;
  shp_pkg::shp_core_t core_ff, nxt_core;
  logic tx_ff;
  logic drv_ff;
  logic link_rst_n;

  // chip-select high clears the link
  // cs_n setup before the first falling edge keeps the release clear of SCK edges
  assign link_rst_n = resetn & ~cs_n;

  always_comb begin
    nxt_bit = bit_ff;
    nxt_xfer = xfer_ff;
    nxt_bit.cnt = bit_ff.cnt + 3'h1;
    nxt_bit.sh = {bit_ff.sh[5:0], sdi_sense};
    if (bit_ff.cnt == `SHP_CNT_LAST) begin
      if (!bit_ff.ctrl_done) begin
        nxt_bit.ctrl_done = 1'b1;
        nxt_bit.rw = bit_ff.sh[`SHP_RW_BIT - 1];
        nxt_xfer.addr = {bit_ff.sh[5:0], sdi_sense};
        if (bit_ff.sh[`SHP_RW_BIT - 1]) begin
          nxt_xfer.rt = ~xfer_ff.rt;
        end
      end else if (bit_ff.rw) begin
        nxt_xfer.addr = xfer_ff.addr + 7'h01;
        nxt_xfer.rt = ~xfer_ff.rt;
      end else begin
        nxt_xfer.wdata = {bit_ff.sh, sdi_sense};
        nxt_xfer.wt = ~xfer_ff.wt;
      end
    end
  end

  // mode 3: sample on rising edge
  always_ff @(posedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_ff <= '0;
    end else begin
      bit_ff <= nxt_bit;
    end
  end

  // handed words survive the chip-select rise so the system side can still take them
  always_ff @(posedge sck or negedge resetn) begin
    if (!resetn) begin
      xfer_ff <= '0;
    end else begin
      xfer_ff <= nxt_xfer;
    end
  end

  // change output on falling edge
  // rd_byte is stable here only when the host keeps the read gap after each byte
  always_ff @(negedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_ff <= 1'b0;
      drv_ff <= 1'b0;
    end else begin
      drv_ff <= bit_ff.ctrl_done & bit_ff.rw;
      tx_ff <= core_ff.rd_byte[~bit_ff.cnt];
    end
  end

  // ==========================================================
  // system domain: selection, two-wire slave, register port
  logic scl_rise;
  logic scl_fall;
  logic sda;
  logic start_cond;
  logic stop_cond;
  logic spi_4w;

  always_comb begin
    scl_rise = core_ff.scl_s[2:1] == 2'b01;
    scl_fall = core_ff.scl_s[2:1] == 2'b10;
    sda = core_ff.sda_s[1];
    start_cond = core_ff.scl_s[2] & core_ff.scl_s[1] & (core_ff.sda_s[2:1] == 2'b10);
    stop_cond = core_ff.scl_s[2] & core_ff.scl_s[1] & (core_ff.sda_s[2:1] == 2'b01);
    nxt_core = core_ff;
    nxt_core.csb_s = {core_ff.csb_s[0], cs_n};
    nxt_core.scl_s = {core_ff.scl_s[1:0], sck};
    nxt_core.sda_s = {core_ff.sda_s[1:0], sdi_sense};
    nxt_core.sdo_s = {core_ff.sdo_s[0], serial_out_addr_pin_sense};
    nxt_core.wt_s = {core_ff.wt_s[1:0], xfer_ff.wt};
    nxt_core.rt_s = {core_ff.rt_s[1:0], xfer_ff.rt};
    // 3-wire selected by the mode bit
    nxt_core.m3 = spi_3wire;
    nxt_core.irq = irq;
    nxt_core.int_en = int_en;
    nxt_core.req.wr = 1'b0;
    nxt_core.req.rd = 1'b0;
    nxt_core.fetch = core_ff.req.rd;
    if (core_ff.fetch) begin
      nxt_core.rd_byte = reg_rdata;
    end
    if (!core_ff.csb_s[1]) begin
      nxt_core.spi_sel = 1'b1;
    end
    if (core_ff.strap != `SHP_STRAP_DONE) begin
      nxt_core.strap = core_ff.strap + 2'h1;
    end
    if (core_ff.strap == `SHP_STRAP_TAKE) begin
      nxt_core.addr_lsb = core_ff.sdo_s[1];
    end
    // SPI accesses reach the register port
    if (core_ff.wt_s[2] != core_ff.wt_s[1]) begin
      nxt_core.req.wr = 1'b1;
      nxt_core.req.addr = xfer_ff.addr;
      nxt_core.req.wdata = xfer_ff.wdata;
    end else if (core_ff.rt_s[2] != core_ff.rt_s[1]) begin
      nxt_core.req.rd = 1'b1;
      nxt_core.req.addr = xfer_ff.addr;
    end
    // two-wire slave, oversampled at the system clock
    if (core_ff.spi_sel) begin
      nxt_core.st = shp_pkg::I_IDLE;
      nxt_core.sda_oe = 1'b0;
    end else if (start_cond) begin
      nxt_core.st = shp_pkg::I_RX;
      nxt_core.kind = shp_pkg::K_ADDR;
      nxt_core.cnt = 3'h0;
      nxt_core.sda_oe = 1'b0;
    end else if (stop_cond) begin
      nxt_core.st = shp_pkg::I_IDLE;
      nxt_core.sda_oe = 1'b0;
    end else begin
      case (core_ff.st)
        shp_pkg::I_RX: begin
          if (scl_rise) begin
            nxt_core.sh = {core_ff.sh[6:0], sda};
            nxt_core.cnt = core_ff.cnt + 3'h1;
            if (core_ff.cnt == `SHP_CNT_LAST) begin
              nxt_core.st = shp_pkg::I_ACK;
            end
          end
        end
        shp_pkg::I_ACK: begin
          if (scl_fall) begin
            nxt_core.sda_oe = 1'b1;
            nxt_core.st = shp_pkg::I_ACKH;
            case (core_ff.kind)
              shp_pkg::K_ADDR: begin
                // answer only to the strapped address
                if (core_ff.sh[7:1] == {`SHP_I2C_ADDR_HI, core_ff.addr_lsb}) begin
                  nxt_core.rw = core_ff.sh[0];
                  if (core_ff.sh[0]) begin
                    nxt_core.req.rd = 1'b1;
                    nxt_core.req.addr = core_ff.ptr;
                    nxt_core.ptr = core_ff.ptr + 7'h01;
                  end
                end else begin
                  nxt_core.sda_oe = 1'b0;
                  nxt_core.st = shp_pkg::I_IDLE;
                end
              end
              shp_pkg::K_PTR: begin
                nxt_core.ptr = core_ff.sh[6:0];
              end
              default: begin
                nxt_core.req.wr = 1'b1;
                nxt_core.req.addr = core_ff.ptr;
                nxt_core.req.wdata = core_ff.sh;
                nxt_core.ptr = core_ff.ptr + 7'h01;
              end
            endcase
          end
        end
        shp_pkg::I_ACKH: begin
          if (scl_fall) begin
            nxt_core.kind = (core_ff.kind == shp_pkg::K_ADDR) ? shp_pkg::K_PTR : shp_pkg::K_DATA;
            if (core_ff.rw) begin
              nxt_core.st = shp_pkg::I_TX;
              nxt_core.sda_oe = ~core_ff.rd_byte[7];
              nxt_core.cnt = 3'h1;
            end else begin
              nxt_core.st = shp_pkg::I_RX;
              nxt_core.sda_oe = 1'b0;
              nxt_core.cnt = 3'h0;
            end
          end
        end
        shp_pkg::I_TX: begin
          if (scl_fall) begin
            nxt_core.cnt = core_ff.cnt + 3'h1;
            if (core_ff.cnt == 3'h0) begin
              nxt_core.sda_oe = 1'b0;
              nxt_core.st = shp_pkg::I_MACK;
            end else begin
              nxt_core.sda_oe = ~core_ff.rd_byte[~core_ff.cnt];
            end
          end
        end
        shp_pkg::I_MACK: begin
          if (scl_rise) begin
            if (!sda) begin
              nxt_core.req.rd = 1'b1;
              nxt_core.req.addr = core_ff.ptr;
              nxt_core.ptr = core_ff.ptr + 7'h01;
              nxt_core.st = shp_pkg::I_ACKH;
            end else begin
              nxt_core.st = shp_pkg::I_IDLE;
            end
          end
        end
        default: begin
          nxt_core.st = shp_pkg::I_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      core_ff <= '0;
      // pins idle high: a zero here would read as chip-select low and lock SPI at every reset
      core_ff.csb_s <= 2'h3;
      core_ff.scl_s <= 3'h7;
      core_ff.sda_s <= 3'h7;
    end else if (ce) begin
      core_ff <= nxt_core;
    end
  end

  // ==========================================================
  // pin and port drive
  assign spi_4w = core_ff.spi_sel & ~core_ff.m3;
  assign reg_req = core_ff.req;
  assign spi_sel = core_ff.spi_sel;
  // two-wire pulls low only; 3-wire SPI turns the data pin around
  assign sdi_drive = core_ff.spi_sel ? tx_ff : 1'b0;
  assign sdi_oe = core_ff.spi_sel ? (core_ff.m3 & drv_ff) : core_ff.sda_oe;
  // interrupt on the strap pin except in 4-wire SPI
  assign serial_out_addr_pin_drive = spi_4w ? tx_ff : core_ff.irq;
  assign serial_out_addr_pin_oe = spi_4w ? drv_ff :
                                  (core_ff.int_en & (core_ff.strap == `SHP_STRAP_DONE));

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_lock_sticky: assert property (core_ff.spi_sel && ce |=> core_ff.spi_sel)
    else $error("two-wire lockout released");
  chk_select_spi: assert property (ce && !core_ff.csb_s[1] |=> core_ff.spi_sel)
    else $error("chip-select low did not select SPI");
  chk_i2c_idle_spi: assert property (core_ff.spi_sel && ce |=> core_ff.st == shp_pkg::I_IDLE && !core_ff.sda_oe)
    else $error("two-wire slave active after SPI lock");
  chk_no_irq_4wire: assert property (spi_4w && !drv_ff |-> !serial_out_addr_pin_oe)
    else $error("strap pin driven in 4-wire SPI without read");
  chk_irq_on_pin: assert property (!core_ff.spi_sel && core_ff.int_en && core_ff.strap == `SHP_STRAP_DONE
                                   |-> serial_out_addr_pin_oe && serial_out_addr_pin_drive == core_ff.irq)
    else $error("interrupt not on strap pin");
  chk_no_3w_4wire: assert property (spi_4w |-> !sdi_oe)
    else $error("data pin driven in 4-wire SPI");
  chk_rd_capture: assert property (reg_req.rd && ce ##1 ce |=> core_ff.rd_byte == $past(reg_rdata))
    else $error("read data not captured");
  chk_ptr_step: assert property (!core_ff.spi_sel && reg_req.rd && $past(ce) |-> core_ff.ptr == reg_req.addr + 7'h01)
    else $error("two-wire address did not step");
  chk_strap_hold: assert property (core_ff.strap == `SHP_STRAP_DONE |=> $stable(core_ff.addr_lsb))
    else $error("address strap changed");
  chk_cs_quiet: assert property (core_ff.csb_s[1] && core_ff.csb_s[0] |-> !drv_ff && bit_ff.cnt == 3'h0)
    else $error("SPI active with chip-select high");
  chk_ctrl_latch: assert property (@(posedge sck) disable iff (!link_rst_n)
                                   bit_ff.cnt == 3'h7 && !bit_ff.ctrl_done |=> bit_ff.ctrl_done)
    else $error("control byte not taken after eight bits");

  cov_spi_write: cover property (core_ff.spi_sel && reg_req.wr);
  cov_spi_read: cover property (core_ff.spi_sel && reg_req.rd ##[1:400] reg_req.rd);
  cov_i2c_write: cover property (!core_ff.spi_sel && reg_req.wr);
  cov_i2c_read: cover property (!core_ff.spi_sel && core_ff.st == shp_pkg::I_MACK);
endmodule : shp_serial_port

// ---- tb/shp_host_model.sv ----
// host side model: mode-3 spi master and two-wire master driving the sensor port pins
`timescale 1ns/100ps
module shp_host_model (
  // pins toward the port
  output logic cs_n,
  output logic sck,
  output logic mosi,
  output logic mosi_oe,
  // resolved data line coming back
  input wire logic miso_line,
  input wire logic sda_line
);
  // =========================================
  // idle pins
  initial begin
    cs_n = 1'b1;
    sck = 1'b1;
    mosi = 1'b1;
    mosi_oe = 1'b1;
  end
  // =========================================
  // byte and frame tasks
  // shift on fall, sample on rise, msb first
  task automatic xfer(input logic [7:0] tx, input logic drive, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      mosi_oe = drive;
      mosi = drive ? tx[i] : ~mosi;
      #15;
      sck = 1'b1;
      rx[i] = miso_line;
      #15;
    end
    // clock held high long enough for the next read byte to be fetched
    #300;
  endtask : xfer
  // control byte with bit7 clear, then one data byte
  task automatic spi_write(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    cs_n = 1'b0;
    #20;
    xfer({1'b0, a}, 1'b1, r);
    xfer(d, 1'b1, r);
    #20;
    cs_n = 1'b1;
    #60;
  endtask : spi_write
  // control byte with bit7 set, n bytes back, chip select high ends
  task automatic spi_read(input logic [6:0] a, input int n, input logic three, output logic [31:0] q);
    logic [7:0] r;
    cs_n = 1'b0;
    #20;
    xfer({1'b1, a}, 1'b1, r);
    for (int i = 0; i < n; i++) begin
      xfer(8'h00, ~three, r);
      q[8*i +: 8] = r;
    end
    #20;
    cs_n = 1'b1;
    mosi_oe = 1'b1;
    #60;
  endtask : spi_read
  // =========================================
  // two-wire master: the data line is only pulled low; i2c_stop drives it high again at its end
  task automatic sda_set(input logic v);
    mosi = 1'b0;
    mosi_oe = ~v;
  endtask : sda_set
  // start or repeated start, data falls while the clock is high
  task automatic i2c_start();
    sda_set(1'b1);
    #100;
    sck = 1'b1;
    #200;
    sda_set(1'b0);
    #200;
    sck = 1'b0;
  endtask : i2c_start
  task automatic i2c_stop();
    #100;
    sda_set(1'b0);
    #100;
    sck = 1'b1;
    #200;
    sda_set(1'b1);
    #200;
    mosi = 1'b1;
    mosi_oe = 1'b1;
  endtask : i2c_stop
  // data set mid low phase, line sampled mid high phase
  task automatic i2c_bit(input logic b, output logic r);
    #100;
    sda_set(b);
    #100;
    sck = 1'b1;
    #100;
    r = sda_line;
    #100;
    sck = 1'b0;
  endtask : i2c_bit
  // eight bits then the acknowledge bit; a 1 releases the line for the port
  task automatic i2c_byte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(tx[i], rx[i]);
    end
    i2c_bit(ack_in, ack);
  endtask : i2c_byte
endmodule : shp_host_model

// ---- tb/test_sensor_serial_host_port.sv ----
// testbench of the sensor serial host port, spi and two-wire sides
`timescale 1ns/100ps
module test_sensor_serial_host_port;
  logic clk, resetn, ce, spi_3wire, int_en, irq, strap_up;
  logic [7:0] reg_rdata = 8'h00;
  shp_pkg::shp_req_t reg_req;
  logic spi_sel, sdi_drive, sdi_oe, sop_drive, sop_oe;
  logic cs_n, sck, mosi, mosi_oe;
  int num_errors = 0;
  int check_count = 0;
  int wr_cnt = 0;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [6:0] rd_q[$];
  // data pin has a pull-up; the strap pin rests at strap_up, high selects the default address
  wire logic sdi_line = sdi_oe ? sdi_drive : (mosi_oe ? mosi : 1'b1);
  wire logic sop_line = sop_oe ? sop_drive : strap_up;
  wire logic miso_line = spi_3wire ? sdi_line : sop_line;

  shp_serial_port DUT (.clk(clk), .resetn(resetn), .ce(ce), .cs_n(cs_n), .sck(sck),
    .sdi_sense(sdi_line), .sdi_drive(sdi_drive), .sdi_oe(sdi_oe),
    .serial_out_addr_pin_sense(sop_line), .serial_out_addr_pin_drive(sop_drive),
    .serial_out_addr_pin_oe(sop_oe), .spi_3wire(spi_3wire), .int_en(int_en), .irq(irq),
    .reg_rdata(reg_rdata), .reg_req(reg_req), .spi_sel(spi_sel));
  shp_host_model HOST (.cs_n(cs_n), .sck(sck), .mosi(mosi), .mosi_oe(mosi_oe), .miso_line(miso_line),
    .sda_line(sdi_line));

  // =========================================
  // clock and register file stand-in
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [7:0] pat(input logic [6:0] a);
    return {a, 1'b1} ^ 8'h3C;
  endfunction : pat
  always @(posedge clk) begin
    if (reg_req.rd) begin
      reg_rdata <= pat(reg_req.addr);
      rd_q.push_back(reg_req.addr);
    end
    if (reg_req.wr) begin
      wr_cnt <= wr_cnt + 1;
      wr_addr <= reg_req.addr;
      wr_data <= reg_req.wdata;
    end
  end

  // =========================================
  // checking and verdict
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  // =========================================
  // scenarios
  task automatic t_idle();
    check("spi_sel", spi_sel, 1'b0);
    check("int oe", sop_oe, 1'b1);
    check("int level", sop_drive, 1'b1);
  endtask : t_idle
  task automatic t_two_wire();
    logic [7:0] rx;
    logic ack;
    int base;
    base = wr_cnt;
    HOST.i2c_start();
    HOST.i2c_byte(8'hEE, 1'b1, rx, ack);
    check("addr ack", {7'h00, ack}, 8'h00);
    HOST.i2c_byte(8'h20, 1'b1, rx, ack);
    check("ptr ack", {7'h00, ack}, 8'h00);
    HOST.i2c_byte(8'h5A, 1'b1, rx, ack);
    HOST.i2c_byte(8'hC3, 1'b1, rx, ack);
    check("data ack", {7'h00, ack}, 8'h00);
    HOST.i2c_stop();
    check("i2c wr count", 8'(wr_cnt - base), 8'h02);
    check("i2c wr addr", {1'b0, wr_addr}, 8'h21);
    check("i2c wr data", wr_data, 8'hC3);
    rd_q.delete();
    HOST.i2c_start();
    HOST.i2c_byte(8'hEE, 1'b1, rx, ack);
    HOST.i2c_byte(8'h30, 1'b1, rx, ack);
    HOST.i2c_start();
    HOST.i2c_byte(8'hEF, 1'b1, rx, ack);
    check("read addr ack", {7'h00, ack}, 8'h00);
    HOST.i2c_byte(8'hFF, 1'b0, rx, ack);
    check("i2c byte 0", rx, pat(7'h30));
    HOST.i2c_byte(8'hFF, 1'b1, rx, ack);
    check("i2c byte 1", rx, pat(7'h31));
    HOST.i2c_stop();
    check("i2c rd count", 8'(rd_q.size()), 8'h02);
    check("i2c rd addr", {1'b0, rd_q[1]}, 8'h31);
    HOST.i2c_start();
    HOST.i2c_byte(8'hEC, 1'b1, rx, ack);
    check("other addr ack", {7'h00, ack}, 8'h01);
    HOST.i2c_stop();
    check("spi_sel", spi_sel, 1'b0);
  endtask : t_two_wire
  task automatic t_write();
    int base;
    base = wr_cnt;
    HOST.spi_write(7'h05, 8'hA5);
    repeat (4) @(posedge clk);
    check("wr count", 8'(wr_cnt - base), 8'h01);
    check("wr addr", {1'b0, wr_addr}, 8'h05);
    check("wr data", wr_data, 8'hA5);
    check("spi_sel", spi_sel, 1'b1);
  endtask : t_write
  task automatic t_read(input logic three, input logic [6:0] a);
    logic [31:0] q;
    @(posedge clk);
    spi_3wire <= three;
    irq <= ~three;
    repeat (3) @(posedge clk);
    rd_q.delete();
    HOST.spi_read(a, 3, three, q);
    repeat (4) @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      check("read byte", q[8*i +: 8], pat(a + 7'(i)));
      check("read addr", {1'b0, rd_q[i]}, {1'b0, a + 7'(i)});
    end
    check("data oe", sdi_oe, 1'b0);
    check("int oe", sop_oe, three);
    if (three) begin
      check("int level", sop_drive, 1'b0);
    end
    check("spi_sel", spi_sel, 1'b1);
  endtask : t_read
  task automatic t_lockout();
    logic [7:0] rx;
    logic ack;
    HOST.i2c_start();
    HOST.i2c_byte(8'hEE, 1'b1, rx, ack);
    HOST.i2c_stop();
    check("locked ack", {7'h00, ack}, 8'h01);
    check("locked oe", sdi_oe, 1'b0);
    check("spi_sel", spi_sel, 1'b1);
  endtask : t_lockout
  task automatic t_strap_low();
    logic [7:0] rx;
    logic ack;
    @(posedge clk);
    resetn <= 1'b0;
    strap_up <= 1'b0;
    spi_3wire <= 1'b0;
    // strap low: interrupt active high, idles low
    irq <= 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    check("spi_sel", spi_sel, 1'b0);
    HOST.i2c_start();
    HOST.i2c_byte(8'hEE, 1'b1, rx, ack);
    check("strapped default ack", {7'h00, ack}, 8'h01);
    HOST.i2c_start();
    HOST.i2c_byte(8'hEC, 1'b1, rx, ack);
    check("strapped low ack", {7'h00, ack}, 8'h00);
    HOST.i2c_stop();
    check("int oe", sop_oe, 1'b1);
    check("int level", sop_drive, 1'b0);
  endtask : t_strap_low

  // =========================================
  // main sequence and watchdog
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    spi_3wire = 1'b0;
    int_en = 1'b1;
    // strap high: interrupt active low, idles high
    irq = 1'b1;
    strap_up = 1'b1;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    t_idle();
    t_two_wire();
    t_write();
    t_read(1'b0, 7'h3E);
    t_read(1'b1, 7'h10);
    t_lockout();
    t_strap_low();
    conclude();
  end
  // the whole run takes about 60 us; this cuts a hang short
  initial begin
    #200000;
    num_errors++;
    conclude();
  end
endmodule : test_sensor_serial_host_port
